/* File: logic/add_and_accumulator_ops.sv */
// add and and datapath for literal and file register forms
//
// Behaviour
// - add literal opcode adds low literal to accumulator, updates carry, digit carry, zero.
// - add file opcode adds accumulator and addressed file register, updates all three flags.
// - file forms write accumulator when destination bit 0, file register when 1.
// - and literal opcode ands accumulator with literal into accumulator, only zero changes.
// - and file opcode ands accumulator with file register, routes by destination bit.
// - file forms decode Q1, read register Q2, compute Q3, write destination Q4.
// - literal forms decode Q1, take literal Q2, compute Q3, write accumulator Q4.
// - port register operands use synchronised pin values, not the output latch.
// - writing timer zero count with destination 1 clears an assigned prescaler.
module add_and_accumulator_ops
  import add_acc_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  // instruction from decode, sampled in Q1
  input  wire logic              i_insn_valid,
  input  wire logic [INSN_W-1:0] i_insn,
  // file register read side
  input  wire logic [DATA_W-1:0] i_file_rdata,
  input  wire logic              i_file_is_port,
  input  wire logic [DATA_W-1:0] i_port_pins,
  // timer prescaler assignment
  input  wire logic              i_prescaler_to_timer,
  // file register access
  output logic [ADDR_W-1:0]      o_file_addr,
  output logic                   o_file_rd,
  output logic                   o_file_wr,
  output logic [DATA_W-1:0]      o_file_wdata,
  output logic                   o_prescaler_clear,
  // accumulator and status
  output logic [DATA_W-1:0]      o_acc,
  output logic                   o_carry,
  output logic                   o_digit_carry_flag,
  output logic                   o_zero,
  output logic                   o_insn_done
);
  function automatic op_e decode_op(input logic [INSN_W-1:0] w);
    if (w[OPC_HI:OPC5_LO] == ADD_LIT_PAT) begin
      return OP_ADD_LIT;
    end else if (w[OPC_HI:OPC6_LO] == AND_LIT_PAT) begin
      return OP_AND_LIT;
    end else if (w[OPC_HI:OPC6_LO] == ADD_FILE_PAT) begin
      return OP_ADD_FILE;
    end else if (w[OPC_HI:OPC6_LO] == AND_FILE_PAT) begin
      return OP_AND_FILE;
    end
    return OP_NONE;
  endfunction : decode_op

  function automatic logic is_file(input op_e o);
    return (o == OP_ADD_FILE) || (o == OP_AND_FILE);
  endfunction : is_file

  phase_e              phase;
  op_e                 op;
  op_e                 next_op;
  logic [DATA_W-1:0]   lit;
  logic [DATA_W-1:0]   next_lit;
  logic                dest_file;
  logic                next_dest_file;
  logic [DATA_W-1:0]   operand;
  logic [DATA_W-1:0]   next_operand;
  logic [DATA_W-1:0]   res;
  logic [DATA_W-1:0]   next_res;
  logic                res_carry;
  logic                next_res_carry;
  logic                res_half;
  logic                next_res_half;
  logic [ADDR_W-1:0]   next_file_addr;
  logic                next_file_rd;
  logic                next_file_wr;
  logic [DATA_W-1:0]   next_file_wdata;
  logic                next_prescaler_clear;
  logic [DATA_W-1:0]   next_acc;
  logic                next_carry;
  logic                next_digit_carry_flag;
  logic                next_zero;
  logic                next_insn_done;
  logic [DATA_W-1:0]   pin_meta;
  logic [DATA_W-1:0]   pin_sync;
  logic [DATA_W:0]     sum_full;
  logic [NIB_W:0]      sum_nib;
  logic [DATA_W-1:0]   insn_lit;

  phase_gen i_phase_gen (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .o_phase    (phase)
  );

  assign insn_lit = i_insn[LIT_HI:0];
  assign sum_full = {1'b0, o_acc} + {1'b0, operand};
  assign sum_nib  = {1'b0, o_acc[NIB_W-1:0]} + {1'b0, operand[NIB_W-1:0]};

  // pins are asynchronous to the core; latch contents never seen here
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta <= ZERO_VAL;
      pin_sync <= ZERO_VAL;
    end else begin
      pin_meta <= i_port_pins;
      pin_sync <= pin_meta;
    end
  end

  always_comb begin
    next_op               = op;
    next_lit              = lit;
    next_dest_file        = dest_file;
    next_operand          = operand;
    next_res              = res;
    next_res_carry        = res_carry;
    next_res_half         = res_half;
    next_file_addr        = o_file_addr;
    next_file_rd          = 1'b0;
    next_file_wr          = 1'b0;
    next_file_wdata       = o_file_wdata;
    next_prescaler_clear  = 1'b0;
    next_acc              = o_acc;
    next_carry            = o_carry;
    next_digit_carry_flag = o_digit_carry_flag;
    next_zero             = o_zero;
    next_insn_done        = 1'b0;
    unique case (phase)
      PH_Q1: begin
        // unsupported words leave op idle so the cycle passes as a no-op
        next_op        = i_insn_valid ? decode_op(i_insn) : OP_NONE;
        next_lit       = insn_lit;
        next_dest_file = i_insn[DEST_BIT];
        next_file_addr = i_insn[ADDR_HI:0];
        next_file_rd   = i_insn_valid && is_file(decode_op(i_insn));
      end
      PH_Q2: begin
        if (is_file(op)) begin
          next_operand = i_file_is_port ? pin_sync : i_file_rdata;
        end else begin
          next_operand = lit;
        end
      end
      PH_Q3: begin
        unique case (op)
          OP_ADD_LIT, OP_ADD_FILE: begin
            next_res       = sum_full[DATA_W-1:0];
            next_res_carry = sum_full[DATA_W];
            next_res_half  = sum_nib[NIB_W];
          end
          OP_AND_LIT, OP_AND_FILE: begin
            next_res = o_acc & operand;
          end
          OP_NONE: begin
            next_res = res;
          end
        endcase
        next_file_wr    = is_file(op) && dest_file;
        next_file_wdata = next_res;
        next_prescaler_clear = is_file(op) && dest_file && i_prescaler_to_timer
                               && (o_file_addr == TIMER_ZERO_ADDR);
      end
      PH_Q4: begin
        if (op != OP_NONE) begin
          if (!(is_file(op) && dest_file)) begin
            next_acc = res;
          end
          next_zero = (res == ZERO_VAL);
          // logic forms leave carry and digit carry untouched
          if (op == OP_ADD_LIT || op == OP_ADD_FILE) begin
            next_carry            = res_carry;
            next_digit_carry_flag = res_half;
          end
          next_insn_done = 1'b1;
        end
        next_op = OP_NONE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op                 <= OP_NONE;
      lit                <= ZERO_VAL;
      dest_file          <= 1'b0;
      operand            <= ZERO_VAL;
      res                <= ZERO_VAL;
      res_carry          <= 1'b0;
      res_half           <= 1'b0;
      o_file_addr        <= '0;
      o_file_rd          <= 1'b0;
      o_file_wr          <= 1'b0;
      o_file_wdata       <= ZERO_VAL;
      o_prescaler_clear  <= 1'b0;
      o_acc              <= ACC_RST;
      o_carry            <= 1'b0;
      o_digit_carry_flag <= 1'b0;
      o_zero             <= 1'b0;
      o_insn_done        <= 1'b0;
    end else begin
      op                 <= next_op;
      lit                <= next_lit;
      dest_file          <= next_dest_file;
      operand            <= next_operand;
      res                <= next_res;
      res_carry          <= next_res_carry;
      res_half           <= next_res_half;
      o_file_addr        <= next_file_addr;
      o_file_rd          <= next_file_rd;
      o_file_wr          <= next_file_wr;
      o_file_wdata       <= next_file_wdata;
      o_prescaler_clear  <= next_prescaler_clear;
      o_acc              <= next_acc;
      o_carry            <= next_carry;
      o_digit_carry_flag <= next_digit_carry_flag;
      o_zero             <= next_zero;
      o_insn_done        <= next_insn_done;
    end
  end

  // checks
  sequence s_start(op_e o);
    phase == PH_Q1 && i_insn_valid && decode_op(i_insn) == o;
  endsequence

  sequence s_file_steps;
    o_file_rd ##1 (!o_file_rd && !o_file_wr) ##1 (!o_file_rd && o_file_wr == dest_file);
  endsequence

  property p_add_lit;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q4 && op == OP_ADD_LIT) |=>
      o_acc == DATA_W'($past(o_acc) + $past(lit)) && o_carry == $past(res_carry);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

  property p_add_file;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q3 && op == OP_ADD_FILE) |=>
      res == DATA_W'($past(o_acc) + $past(operand))
      && res_half == (int'($past(o_acc[NIB_W-1:0])) + int'($past(operand[NIB_W-1:0]))
                      >= 2 ** NIB_W);
  endproperty
  a_add_file: assert property (p_add_file) else $error("add file sum wrong");

  property p_dest_file;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q3 && is_file(op) && dest_file) |=>
      o_file_wr && o_file_wdata == res ##1 (o_acc == $past(o_acc) && !o_file_wr);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_and_lit;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q4 && op == OP_AND_LIT) |=>
      o_acc == ($past(o_acc) & $past(lit)) && $stable(o_carry) && $stable(o_digit_carry_flag);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

  property p_and_file;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    s_start(OP_AND_FILE) |-> ##4 ($stable(o_carry) && $stable(o_digit_carry_flag));
  endproperty
  a_and_file: assert property (p_and_file) else $error("and file touched carry");

  property p_file_phases;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (s_start(OP_ADD_FILE) or s_start(OP_AND_FILE)) |=> s_file_steps;
  endproperty
  a_file_phases: assert property (p_file_phases) else $error("file phase order wrong");

  property p_lit_phases;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (s_start(OP_ADD_LIT) or s_start(OP_AND_LIT)) |=> (!o_file_rd && !o_file_wr) [*3];
  endproperty
  a_lit_phases: assert property (p_lit_phases) else $error("literal touched file");

  property p_one_cycle;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q1 && i_insn_valid && decode_op(i_insn) != OP_NONE) |->
      ##4 (o_insn_done && phase == PH_Q1);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("not done in one cycle");

  property p_zero;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q4 && op != OP_NONE) |=> o_zero == ($past(res) == ZERO_VAL);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_port_pins;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q2 && is_file(op) && i_file_is_port) |=> operand == $past(pin_sync);
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("port operand not from pins");

  property p_prescaler;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (phase == PH_Q3 && is_file(op) && dest_file && i_prescaler_to_timer
     && o_file_addr == TIMER_ZERO_ADDR) |=>
      (o_prescaler_clear && o_file_wr) ##1 !o_prescaler_clear;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");
endmodule : add_and_accumulator_ops

/* File: logic/add_acc_pkg.sv */
// shared constants and types for the add and accumulator datapath
package add_acc_pkg;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int INSN_W  = 14;
  localparam int NIB_W   = 4;
  // instruction field positions
  localparam int OPC_HI  = 13;
  localparam int OPC5_LO = 9;
  localparam int OPC6_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int LIT_HI  = 7;
  localparam int ADDR_HI = 6;
  // opcode patterns
  localparam logic [4:0] ADD_LIT_PAT  = 5'h1F;
  localparam logic [5:0] AND_LIT_PAT  = 6'h39;
  localparam logic [5:0] ADD_FILE_PAT = 6'h07;
  localparam logic [5:0] AND_FILE_PAT = 6'h05;
  // file address of the timer zero count register
  localparam logic [ADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01;
  // reset values
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_LIT,
    OP_ADD_FILE,
    OP_AND_LIT,
    OP_AND_FILE
  } op_e;
endpackage : add_acc_pkg

/* File: logic/phase_gen.sv */
// four-phase instruction cycle sequencer
module phase_gen
  import add_acc_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  // phase
  output phase_e    o_phase
);
  phase_e next_phase;

  always_comb begin
    unique case (o_phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_phase <= PH_Q1;
    end else begin
      o_phase <= next_phase;
    end
  end
endmodule : phase_gen

/* File: tb/add_and_accumulator_ops_test.sv */
// self-checking bench for the add and and datapath
module add_and_accumulator_ops_test
  import add_acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_core_clk;
  logic              i_arst_n;
  logic              i_insn_valid;
  logic [INSN_W-1:0] i_insn;
  logic [DATA_W-1:0] i_file_rdata;
  logic              i_file_is_port;
  logic [DATA_W-1:0] i_port_pins;
  logic              i_prescaler_to_timer;
  logic [ADDR_W-1:0] o_file_addr;
  logic              o_file_rd;
  logic              o_file_wr;
  logic [DATA_W-1:0] o_file_wdata;
  logic              o_prescaler_clear;
  logic [DATA_W-1:0] o_acc;
  logic              o_carry;
  logic              o_digit_carry_flag;
  logic              o_zero;
  logic              o_insn_done;

  int     n_errors;
  int     n_compared;
  integer seed;
  int     acc_m;
  int     c_m;
  int     half_m;
  int     z_m;
  int     pend;
  int     exp_done;

  add_and_accumulator_ops i_add_and_accumulator_ops (
    .i_core_clk           (i_core_clk),
    .i_arst_n             (i_arst_n),
    .i_insn_valid         (i_insn_valid),
    .i_insn               (i_insn),
    .i_file_rdata         (i_file_rdata),
    .i_file_is_port       (i_file_is_port),
    .i_port_pins          (i_port_pins),
    .i_prescaler_to_timer (i_prescaler_to_timer),
    .o_file_addr          (o_file_addr),
    .o_file_rd            (o_file_rd),
    .o_file_wr            (o_file_wr),
    .o_file_wdata         (o_file_wdata),
    .o_prescaler_clear    (o_prescaler_clear),
    .o_acc                (o_acc),
    .o_carry              (o_carry),
    .o_digit_carry_flag   (o_digit_carry_flag),
    .o_zero               (o_zero),
    .o_insn_done          (o_insn_done)
  );

  task automatic summarize();
    $display("n_compared=%0d n_errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // results land at the end of Q4, so they are judged one Q1 later
  task automatic check_prev();
    if (pend != 0) begin
      chk(8'(o_insn_done), 8'(exp_done));
      chk(o_acc, 8'(acc_m));
      chk(8'(o_carry), 8'(c_m));
      chk(8'(o_digit_carry_flag), 8'(half_m));
      chk(8'(o_zero), 8'(z_m));
    end
  endtask : check_prev

  // pins need two stable cycles before a port read, hence an empty slot
  task automatic idle(input logic [7:0] pins);
    i_insn_valid <= 1'b0;
    i_port_pins  <= pins;
    #1;
    check_prev();
    exp_done = 0;
    pend     = 1;
    repeat (4) @(posedge i_core_clk);
  endtask : idle

  task automatic exec(input op_e op, input logic d, input logic [6:0] f, input logic [7:0] k,
                      input logic [7:0] fdata, input logic port, input logic pre, input logic x);
    logic [13:0] w;
    logic        file_f;
    logic        wr_e;
    int          opnd;
    int          res;
    case (op)
      OP_ADD_LIT:  w = {ADD_LIT_PAT, x, k};
      OP_AND_LIT:  w = {AND_LIT_PAT, k};
      OP_ADD_FILE: w = {ADD_FILE_PAT, d, f};
      OP_AND_FILE: w = {AND_FILE_PAT, d, f};
      default:     w = {6'h08, d, f};
    endcase
    file_f = (op == OP_ADD_FILE) || (op == OP_AND_FILE);
    i_insn_valid         <= 1'b1;
    i_insn               <= w;
    i_prescaler_to_timer <= pre;
    i_file_rdata         <= 8'($random(seed));
    i_file_is_port       <= 1'($random(seed));
    if (!port) begin
      i_port_pins <= 8'($random(seed));
    end
    #1;
    check_prev();
    opnd = file_f ? (port ? int'(i_port_pins) : int'(fdata)) : int'(k);
    res  = acc_m & opnd;
    if (op == OP_ADD_LIT || op == OP_ADD_FILE) begin
      res  = (acc_m + opnd) & 255;
      c_m  = (acc_m + opnd) >> 8;
      half_m = ((acc_m & 15) + (opnd & 15)) >> 4;
    end
    wr_e = file_f && d;
    if (op != OP_NONE) begin
      z_m = (res == 0);
      if (!wr_e) begin
        acc_m = res;
      end
    end
    exp_done = (op != OP_NONE);
    @(posedge i_core_clk);
    // valid and word outside Q1 must be ignored
    i_insn_valid   <= 1'($random(seed));
    i_insn         <= 14'($random(seed));
    i_file_rdata   <= fdata;
    i_file_is_port <= port;
    #1;
    chk(8'(o_file_rd), 8'(file_f));
    if (file_f) begin
      chk(8'(o_file_addr), 8'(f));
    end
    @(posedge i_core_clk);
    i_file_rdata   <= 8'($random(seed));
    i_file_is_port <= 1'($random(seed));
    #1;
    chk(8'(o_file_rd), 8'h00);
    @(posedge i_core_clk);
    #1;
    chk(8'(o_file_wr), 8'(wr_e));
    if (wr_e) begin
      chk(o_file_wdata, 8'(res));
    end
    chk(8'(o_prescaler_clear), 8'(wr_e && f == TIMER_ZERO_ADDR && pre));
    chk(8'(o_insn_done), 8'h00);
    pend = 1;
    @(posedge i_core_clk);
  endtask : exec

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    int r;
    n_errors = 0;
    n_compared = 0;
    seed = 32'hdd7986da;
    acc_m = 0;
    c_m = 0;
    half_m = 0;
    z_m = 0;
    pend = 0;
    exp_done = 0;
    i_arst_n = 1'b0;
    i_insn_valid = 1'b0;
    i_insn = 14'h0000;
    i_file_rdata = 8'h00;
    i_file_is_port = 1'b0;
    i_port_pins = 8'h00;
    i_prescaler_to_timer = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    exec(OP_ADD_LIT, 0, 0, 8'h10, 0, 0, 0, 0);
    exec(OP_ADD_LIT, 0, 0, 8'h15, 0, 0, 0, 1);
    exec(OP_AND_LIT, 0, 0, 8'h00, 0, 0, 0, 0);
    exec(OP_ADD_LIT, 0, 0, 8'hA3, 0, 0, 0, 0);
    exec(OP_AND_LIT, 0, 0, 8'h5F, 0, 0, 0, 0);
    exec(OP_ADD_LIT, 0, 0, 8'hFD, 0, 0, 0, 0);
    exec(OP_ADD_FILE, 1, TIMER_ZERO_ADDR, 0, 8'h0F, 0, 1, 0);
    exec(OP_AND_FILE, 1, TIMER_ZERO_ADDR, 0, 8'hC2, 0, 0, 0);
    exec(OP_NONE, 1, 7'h22, 0, 8'h33, 0, 1, 0);
    idle(8'h5A);
    exec(OP_ADD_FILE, 0, 7'h06, 0, 8'hFF, 1, 0, 0);
    // mixed traffic, back to back, with port reads behind an empty slot
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      if (r[17:16] == 2'b00) begin
        idle(r[31:24]);
      end
      exec(op_e'(3'(r[2:0] % 3'd5)), r[19], r[9] ? TIMER_ZERO_ADDR : r[16:10],
           8'($random(seed)), 8'($random(seed)),
           r[17:16] == 2'b00, r[18], r[20]);
    end
    i_insn_valid <= 1'b0;
    #1;
    check_prev();
    summarize();
  end
endmodule : add_and_accumulator_ops_test
